/* rtl/srsr_core.sv */
// Status byte, masks, trip latch, link settings and service request.
// Assumes one-cycle command strobes from a parser on sys_clk_i, and
// trip conditions and the polling/clear events from asynchronous pins.
`timescale 1ns/1ps
module srsr_core #(
  parameter int ADDR_MAX = 15
) (
  // Clock and reset
  input  wire logic       sys_clk_i,
  input  wire logic       rst_n_i,
  // Option straps and link events
  input  wire logic       par_bus_fitted_i,
  input  wire logic       powerup_flag_i,
  input  wire logic       program_run_complete_i,
  input  wire logic       link_request_i,
  input  wire logic [7:0] trip_cond_i,
  input  wire logic       device_clear_i,
  input  wire logic       serial_poll_i,
  input  wire logic       group_trigger_i,
  // Command strobes from parser
  input  wire logic       req_mask_write_i,
  input  wire logic       trip_enable_write_i,
  input  wire logic       term_write_i,
  input  wire logic       label_write_i,
  input  wire logic       target_write_i,
  input  wire logic       lockout_write_i,
  input  wire logic       quiet_write_i,
  input  wire logic       alarm_reset_i,
  input  wire logic       sw_trigger_i,
  input  wire logic [7:0] cmd_data_i,
  input  wire logic       err_valid_i,
  input  wire logic [7:0] err_code_i,
  // Serial receive codes and command completion
  input  wire logic       rx_valid_i,
  input  wire logic [7:0] rx_code_i,
  input  wire logic       cmd_done_i,
  // Query port
  input  wire logic       query_i,
  input  wire logic [2:0] query_sel_i,
  // Reply and settings
  output logic [7:0]      reply_data_o,
  output logic            reply_valid_o,
  output logic            reply_label_o,
  output logic [1:0]      reply_term_o,
  output logic [4:0]      link_target_o,
  output logic [4:0]      answer_addr_o,
  output logic            panel_locked_o,
  output logic            ack_enable_o,
  output logic            tx_suspend_o,
  output logic            hold_off_o,
  output logic            alarm_clear_o,
  output logic            trigger_o,
  output logic            service_req_o,
  output logic [7:0]      summary_o
);

  // ----------------------------------------
  // Input synchronisers
  // ----------------------------------------
  localparam int SW = 14;
  logic [SW-1:0] sync1_q, sync2_q, sync1_d, sync2_d;
  logic [SW-1:0] edge_q, edge_d;
  logic [SW-1:0] raw;
  assign raw = {group_trigger_i, serial_poll_i, device_clear_i, link_request_i,
                program_run_complete_i, powerup_flag_i, trip_cond_i};

  // Two flops per pin plus an edge flop; edges taken from the second only
  always_comb begin
    sync1_d = raw;
    sync2_d = sync1_q;
    edge_d  = sync2_q;
  end

  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      sync1_q <= '0;
      sync2_q <= '0;
      edge_q  <= '0;
    end else begin
      sync1_q <= sync1_d;
      sync2_q <= sync2_d;
      edge_q  <= edge_d;
    end
  end

  logic [7:0] trip_s;
  logic       pwr_s, seq_s, link_s, dcl_p, poll_p, get_p;
  assign trip_s = sync2_q[7:0];
  assign pwr_s  = sync2_q[8];
  assign seq_s  = sync2_q[9];
  assign link_s = sync2_q[10];
  assign dcl_p  = sync2_q[11] & ~edge_q[11];
  assign poll_p = sync2_q[12] & ~edge_q[12];
  assign get_p  = sync2_q[13] & ~edge_q[13];

  // ----------------------------------------
  // Settings and status state
  // ----------------------------------------
  logic [7:0] rmask_q, rmask_d, tmask_q, tmask_d;
  logic [7:0] trip_q, trip_d, err_q, err_d;
  logic       err_flag_q, err_flag_d, rqs_q, rqs_d;
  logic [1:0] term_q, term_d;
  logic       label_q, label_d, lock_q, lock_d, quiet_q, quiet_d;
  logic       susp_q, susp_d, hold_q, hold_d;
  logic [4:0] target_q, target_d;
  logic       rd_trip, rd_err;
  logic [7:0] summary, enabled;

  assign rd_trip = query_i && (query_sel_i == srsr_pkg::SRSR_Q_TRIP);
  assign rd_err  = query_i && (query_sel_i == srsr_pkg::SRSR_Q_ERR);

  // Summary byte assembly
  always_comb begin
    summary = 8'h00;
    summary[srsr_pkg::SUM_TRIP_BIT]   = |(trip_q & tmask_q);
    summary[srsr_pkg::SUM_PWRUP_BIT]  = pwr_s & par_bus_fitted_i;
    summary[srsr_pkg::SUM_SEQEND_BIT] = seq_s;
    summary[srsr_pkg::SUM_ERR_BIT]    = err_flag_q;
    summary[srsr_pkg::SUM_LINK_BIT]   = link_s;
    summary[srsr_pkg::SUM_RQS_BIT]    = rqs_q & par_bus_fitted_i;
    enabled = summary & rmask_q & srsr_pkg::REQ_MASK_USED;
  end

  // Next-state for all settings
  always_comb begin
    rmask_d    = rmask_q;
    tmask_d    = tmask_q;
    trip_d     = trip_q;
    err_d      = err_q;
    err_flag_d = err_flag_q;
    rqs_d      = rqs_q;
    term_d     = term_q;
    label_d    = label_q;
    lock_d     = lock_q;
    quiet_d    = quiet_q;
    susp_d     = susp_q;
    hold_d     = hold_q;
    target_d   = target_q;
    if (req_mask_write_i) begin
      rmask_d = cmd_data_i;
    end
    if (trip_enable_write_i) begin
      tmask_d = cmd_data_i;
    end
    if (term_write_i) begin
      term_d = cmd_data_i[1:0];
    end
    if (label_write_i) begin
      label_d = cmd_data_i[0];
    end
    if (lockout_write_i) begin
      lock_d = cmd_data_i[0];
    end
    if (quiet_write_i) begin
      quiet_d = cmd_data_i[0];
    end
    if (target_write_i && (cmd_data_i <= 8'(ADDR_MAX + 1))) begin
      target_d = cmd_data_i[4:0];
    end
    // trip latch, clear on query; new set wins
    if (rd_trip) begin
      trip_d = 8'h00;
    end
    trip_d = trip_d | trip_s;
    // error bit clears on error query
    if (rd_err) begin
      err_flag_d = 1'b0;
    end
    // device clear drops error and target
    if (dcl_p) begin
      err_d      = srsr_pkg::ERR_RST;
      err_flag_d = 1'b0;
      target_d   = srsr_pkg::TARGET_MASTER;
    end
    if (err_valid_i) begin
      err_d      = err_code_i;
      err_flag_d = 1'b1;
    end
    if (poll_p) begin
      rqs_d = 1'b0;
    end
    if (par_bus_fitted_i && (|enabled)) begin
      rqs_d = 1'b1;
    end
    if (rx_valid_i && (rx_code_i == srsr_pkg::CODE_SUSPEND)) begin
      susp_d = 1'b1;
    end else if (rx_valid_i && (rx_code_i == srsr_pkg::CODE_RESUME)) begin
      susp_d = 1'b0;
    end
    if (cmd_done_i) begin
      hold_d = 1'b0;
    end
    if (rx_valid_i && (rx_code_i == srsr_pkg::CODE_HOLDOFF)) begin
      hold_d = 1'b1;
    end
  end

  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rmask_q    <= srsr_pkg::MASK_RST;
      tmask_q    <= srsr_pkg::MASK_RST;
      trip_q     <= 8'h00;
      err_q      <= srsr_pkg::ERR_RST;
      err_flag_q <= 1'b0;
      rqs_q      <= 1'b0;
      term_q     <= srsr_pkg::TERM_RST;
      label_q    <= 1'b0;
      lock_q     <= 1'b0;
      quiet_q    <= 1'b0;
      susp_q     <= 1'b0;
      hold_q     <= 1'b0;
      target_q   <= srsr_pkg::TARGET_MASTER;
    end else begin
      rmask_q    <= rmask_d;
      tmask_q    <= tmask_d;
      trip_q     <= trip_d;
      err_q      <= err_d;
      err_flag_q <= err_flag_d;
      rqs_q      <= rqs_d;
      term_q     <= term_d;
      label_q    <= label_d;
      lock_q     <= lock_d;
      quiet_q    <= quiet_d;
      susp_q     <= susp_d;
      hold_q     <= hold_d;
      target_q   <= target_d;
    end
  end

  // ----------------------------------------
  // Query reply and one-shot outputs
  // ----------------------------------------
  logic [7:0] reply_q, reply_d;
  logic       rvalid_q, rvalid_d, aclr_q, aclr_d, trig_q, trig_d;

  // Reply picks the value before any read-clear
  always_comb begin
    rvalid_d = query_i;
    aclr_d   = alarm_reset_i; // leave alarm state
    trig_d   = sw_trigger_i | get_p; // software or group trigger
    reply_d  = reply_q;
    if (query_i) begin
      case (query_sel_i)
        srsr_pkg::SRSR_Q_SUM:   reply_d = summary; // summary reply
        srsr_pkg::SRSR_Q_TRIP:  reply_d = trip_q;  // trip reply
        srsr_pkg::SRSR_Q_RMASK: reply_d = rmask_q;
        srsr_pkg::SRSR_Q_TMASK: reply_d = tmask_q;
        srsr_pkg::SRSR_Q_ERR:   reply_d = err_q;   // error code reply
        srsr_pkg::SRSR_Q_TERM:  reply_d = {6'h00, term_q};
        srsr_pkg::SRSR_Q_LABEL: reply_d = {7'h00, label_q};
        default:                reply_d = {3'h0, answer_addr_o};
      endcase
    end
  end

  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      reply_q  <= 8'h00;
      rvalid_q <= 1'b0;
      aclr_q   <= 1'b0;
      trig_q   <= 1'b0;
    end else begin
      reply_q  <= reply_d;
      rvalid_q <= rvalid_d;
      aclr_q   <= aclr_d;
      trig_q   <= trig_d;
    end
  end

  // Outputs; binary reply, decimal text is the formatter's job
  assign reply_data_o   = reply_q;
  assign reply_valid_o  = rvalid_q;
  assign reply_label_o  = label_q;
  assign reply_term_o   = term_q;
  assign link_target_o  = target_q;
  assign answer_addr_o  = (target_q == srsr_pkg::TARGET_BCAST) ?
                          srsr_pkg::TARGET_MASTER : target_q;
  assign panel_locked_o = lock_q;
  assign ack_enable_o   = ~quiet_q;
  assign tx_suspend_o   = susp_q;
  assign hold_off_o     = hold_q;
  assign alarm_clear_o  = aclr_q;
  assign trigger_o      = trig_q;
  assign service_req_o  = rqs_q & par_bus_fitted_i;
  assign summary_o      = summary;

endmodule

/* rtl/srsr_pkg.sv */
// Constants and types for the status reporting and service request block.
// Assumes a command parser upstream that decodes host commands into strobes.
package srsr_pkg;
  // ----------------------------------------
  // Summary status byte fields
  // ----------------------------------------
  localparam int SUM_TRIP_BIT   = 0;
  localparam int SUM_PWRUP_BIT  = 1;
  localparam int SUM_SEQEND_BIT = 2;
  localparam int SUM_ERR_BIT    = 3;
  localparam int SUM_LINK_BIT   = 4;
  localparam int SUM_RQS_BIT    = 6;
  // Request mask bits that can raise a request
  localparam logic [7:0] REQ_MASK_USED = 8'h1D;
  // ----------------------------------------
  // Reset values and codes
  // ----------------------------------------
  localparam logic [7:0] MASK_RST      = 8'h00;
  localparam logic [7:0] ERR_RST       = 8'h00;
  localparam logic [1:0] TERM_RST      = 2'h0;
  localparam logic [4:0] TARGET_MASTER = 5'h00;
  localparam logic [4:0] TARGET_BCAST  = 5'h10;
  localparam logic [7:0] CODE_RESUME   = 8'h11;
  localparam logic [7:0] CODE_SUSPEND  = 8'h13;
  localparam logic [7:0] CODE_HOLDOFF  = 8'h40;
  // Reply terminator codes
  typedef enum logic [1:0] {
    SRSR_TERM_CRLF = 2'h0,
    SRSR_TERM_CR   = 2'h1,
    SRSR_TERM_LF   = 2'h2,
    SRSR_TERM_EOI  = 2'h3
  } srsr_term_t;
  // Reply source select
  typedef enum logic [2:0] {
    SRSR_Q_SUM   = 3'h0,
    SRSR_Q_TRIP  = 3'h1,
    SRSR_Q_RMASK = 3'h2,
    SRSR_Q_TMASK = 3'h3,
    SRSR_Q_ERR   = 3'h4,
    SRSR_Q_TERM  = 3'h5,
    SRSR_Q_LABEL = 3'h6,
    SRSR_Q_OTHER = 3'h7
  } srsr_query_t;
endpackage

/* bench/srsr_asserts.sv */
// Checker bound to the status block ports.
// Assumes one clock and the async low reset.
`timescale 1ns/1ps
module srsr_asserts #(
  parameter int ADDR_MAX = 15
) (
  // Clock, reset, inputs
  input wire logic       sys_clk_i,
  input wire logic       rst_n_i,
  input wire logic       par_bus_fitted_i,
  input wire logic       query_i,
  input wire logic       label_write_i,
  input wire logic       term_write_i,
  input wire logic       target_write_i,
  input wire logic       lockout_write_i,
  input wire logic       quiet_write_i,
  input wire logic [7:0] cmd_data_i,
  // Outputs watched
  input wire logic       reply_valid_o,
  input wire logic       reply_label_o,
  input wire logic [1:0] reply_term_o,
  input wire logic [4:0] link_target_o,
  input wire logic [4:0] answer_addr_o,
  input wire logic       panel_locked_o,
  input wire logic       ack_enable_o,
  input wire logic       service_req_o
);
  // ----------------
  // Properties
  // ----------------
  default clocking @(posedge sys_clk_i);
  endclocking
  default disable iff (!rst_n_i);
  reply_after_query_a: assert property (query_i |=> reply_valid_o)
    else $error("no reply after query");
  label_setting_a: assert property (label_write_i |=> reply_label_o == $past(cmd_data_i[0]))
    else $error("label setting wrong");
  term_setting_a: assert property (term_write_i |=> reply_term_o == $past(cmd_data_i[1:0]))
    else $error("terminator code wrong");
  lockout_setting_a: assert property (lockout_write_i |=> panel_locked_o == $past(cmd_data_i[0]))
    else $error("lockout wrong");
  quiet_ack_a: assert property (quiet_write_i |=> ack_enable_o == !$past(cmd_data_i[0]))
    else $error("acknowledge enable wrong");
  target_store_a: assert property (target_write_i && cmd_data_i <= ADDR_MAX + 1
    |=> link_target_o == $past(cmd_data_i[4:0])) else $error("target not stored");
  bcast_master_a: assert property (link_target_o == 5'h10 |-> answer_addr_o == 5'h00)
    else $error("broadcast not answered as master");
  no_bus_req_a: assert property (!par_bus_fitted_i |-> !service_req_o)
    else $error("request without parallel bus");
  // Main scenarios reached
  cover property (service_req_o);
  cover property (link_target_o == 5'h10);
  cover property (reply_label_o);
endmodule
bind srsr_core srsr_asserts #(.ADDR_MAX(ADDR_MAX)) i_srsr_asserts (.*);

/* bench/srsr_host_model.sv */
// Host side: serial polls the block while it requests service.
// Assumes the bench enables polling when a request should be served.
`timescale 1ns/1ps
module srsr_host_model (
  // Clock and controls
  input  wire logic sys_clk_i,
  input  wire logic poll_en_i,
  input  wire logic service_req_i,
  // Poll event pin
  output logic      serial_poll_o = 1'b0
);
  int n = 0;
  // poll on request; held 4 cycles for the pin synchroniser
  always @(posedge sys_clk_i) begin
    if (poll_en_i && service_req_i && n == 0) n <= 8;
    else if (n > 0) n <= n - 1;
    serial_poll_o <= n > 4;
  end
endmodule

/* bench/test_status_reporting_and_service_request.sv */
// Self-checking bench for the status block.
// Assumes srsr_core, the host model and the bound checker are compiled.
`timescale 1ns/1ps
module test_status_reporting_and_service_request;
  logic        sys_clk_i, rst_n_i, par_bus_fitted_i, serial_poll_i, query_i;
  logic        reply_valid_o, reply_label_o, panel_locked_o, ack_enable_o;
  logic        tx_suspend_o, hold_off_o, alarm_clear_o, trigger_o, service_req_o;
  logic        poll_en, pwr, seq, lnk;
  logic [1:0]  reply_term_o, pins;
  logic [2:0]  query_sel_i;
  logic [4:0]  link_target_o, answer_addr_o;
  logic [7:0]  trip_cond_i, cmd_data_i, reply_data_o, summary_o;
  logic [11:0] wr;
  int          miscompares, check_count, cyc, trig_n, alarm_n;
  localparam logic [7:0] PAT [3] = '{8'h00, 8'hFF, 8'h5A};
  // ----------------
  // Design and host
  // ----------------
  srsr_core i_srsr_core (.*, .powerup_flag_i(pwr), .program_run_complete_i(seq),
    .link_request_i(lnk), .device_clear_i(pins[0]), .group_trigger_i(pins[1]),
    .req_mask_write_i(wr[0]), .trip_enable_write_i(wr[1]), .term_write_i(wr[2]),
    .label_write_i(wr[3]), .target_write_i(wr[4]), .lockout_write_i(wr[5]),
    .quiet_write_i(wr[6]), .alarm_reset_i(wr[7]), .sw_trigger_i(wr[8]),
    .err_valid_i(wr[9]), .err_code_i(cmd_data_i), .rx_valid_i(wr[10]),
    .rx_code_i(cmd_data_i), .cmd_done_i(wr[11]));
  srsr_host_model i_srsr_host_model (.sys_clk_i, .poll_en_i(poll_en),
    .service_req_i(service_req_o), .serial_poll_o(serial_poll_i));
  initial begin
    sys_clk_i = 1'b0;
    forever #20 sys_clk_i = ~sys_clk_i;
  end
  // Event counters and hang guard; pulses too short to poll reliably
  always @(posedge sys_clk_i) begin
    cyc++;
    if (trigger_o === 1'b1) trig_n++;
    if (alarm_clear_o === 1'b1) alarm_n++;
    if (cyc == 20000) begin
      miscompares++;
      wrap_up();
    end
  end
  task automatic wrap_up();
    $display("Checks %0d mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [7:0] got, input logic [7:0] exp);
    check_count++;
    if (got !== exp) begin
      miscompares++;
      $display("Error %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic step(input int n);
    repeat (n) @(posedge sys_clk_i);
  endtask
  // One-cycle strobe with its argument
  task automatic pulse(input int k, input logic [7:0] d);
    @(posedge sys_clk_i);
    wr[k]      <= 1'b1;
    cmd_data_i <= d;
    @(posedge sys_clk_i);
    wr <= '0;
    #1;
  endtask
  task automatic ask(input logic [2:0] s, input logic [7:0] exp, input string nm);
    @(posedge sys_clk_i);
    query_i     <= 1'b1;
    query_sel_i <= s;
    @(posedge sys_clk_i);
    query_i <= 1'b0;
    #1;
    chk("reply valid", 8'(reply_valid_o), 8'h01);
    chk(nm, reply_data_o, exp);
  endtask
  // Asynchronous pin event, long enough for the synchroniser
  task automatic pin(input int k);
    @(posedge sys_clk_i);
    pins[k] <= 1'b1;
    step(4);
    pins[k] <= 1'b0;
    step(6);
    #1;
  endtask
  task automatic trip(input logic [7:0] t);
    @(posedge sys_clk_i);
    trip_cond_i <= t;
    step(3);
    trip_cond_i <= 8'h00;
    step(5);
    #1;
  endtask
  initial begin
    {rst_n_i, par_bus_fitted_i, query_i, poll_en, pins, wr, pwr, seq, lnk} = '0;
    {query_sel_i, trip_cond_i, cmd_data_i} = '0;
    {miscompares, check_count, cyc, trig_n, alarm_n} = '0;
    step(4);
    rst_n_i <= 1'b1;
    step(4);
    chk("ack reset", 8'(ack_enable_o), 8'h01);
    ask(3'h6, 8'h00, "label reset");
    foreach (PAT[i]) begin
      pulse(0, PAT[i]);
      pulse(1, ~PAT[i]);
      ask(3'h2, PAT[i], "request mask");
      ask(3'h3, ~PAT[i], "trip mask");
    end
    for (int c = 0; c < 4; c++) begin
      pulse(2, 8'(c));
      ask(3'h5, 8'(c), "terminator");
    end
    pulse(3, 8'h01);
    ask(3'h6, 8'h01, "label");
    $display("Test settings done");
    pulse(4, 8'h10);
    chk("bcast answer", 8'(answer_addr_o), 8'h00);
    pulse(4, 8'h05);
    pulse(4, 8'h11);
    chk("target", 8'(link_target_o), 8'h05);
    pulse(9, 8'h02);
    pulse(9, 8'h18);
    chk("err bit", 8'(summary_o[3]), 8'h01);
    ask(3'h4, 8'h18, "err code");
    chk("err bit clr", 8'(summary_o[3]), 8'h00);
    pin(0);
    chk("target clr", 8'(link_target_o), 8'h00);
    ask(3'h4, 8'h00, "err clr");
    $display("Test link and error done");
    pulse(1, 8'h04);
    pulse(0, 8'h01);
    @(posedge sys_clk_i);
    par_bus_fitted_i <= 1'b1;
    trip(8'h01);
    chk("masked trip", 8'(service_req_o), 8'h00);
    ask(3'h1, 8'h01, "trip 0");
    trip(8'h04);
    chk("trip sum", 8'(summary_o[0]), 8'h01);
    chk("request", 8'(service_req_o), 8'h01);
    ask(3'h1, 8'h04, "trip 2");
    ask(3'h1, 8'h00, "trip clr");
    @(posedge sys_clk_i);
    poll_en <= 1'b1;
    step(16);
    #1;
    chk("poll clr", 8'(summary_o[6]), 8'h00);
    @(posedge sys_clk_i);
    par_bus_fitted_i <= 1'b0;
    trip(8'h04);
    chk("no bus", 8'(service_req_o), 8'h00);
    $display("Test trip done");
    pulse(5, 8'h01);
    chk("lock", 8'(panel_locked_o), 8'h01);
    pulse(6, 8'h01);
    chk("quiet", 8'(ack_enable_o), 8'h00);
    pulse(10, 8'h13);
    chk("suspend", 8'(tx_suspend_o), 8'h01);
    pulse(10, 8'h11);
    chk("resume", 8'(tx_suspend_o), 8'h00);
    pulse(10, 8'h40);
    chk("hold", 8'(hold_off_o), 8'h01);
    pulse(11, 8'h00);
    chk("release", 8'(hold_off_o), 8'h00);
    pulse(7, 8'h00);
    pulse(8, 8'h00);
    pin(1);
    chk("alarm clr", 8'(alarm_n), 8'h01);
    chk("triggers", 8'(trig_n), 8'h02);
    $display("Test controls done");
    // summary layout, unused mask bit raises nothing
    pulse(0, 8'h02);
    @(posedge sys_clk_i);
    {pwr, seq, lnk} <= 3'b111;
    step(3);
    ask(3'h0, 8'h15, "summary no bus");
    @(posedge sys_clk_i);
    par_bus_fitted_i <= 1'b1;
    ask(3'h0, 8'h17, "summary bus");
    chk("unused mask", 8'(service_req_o), 8'h00);
    pulse(4, 8'h10);
    ask(3'h7, 8'h00, "bcast addr");
    $display("Test summary done");
    wrap_up();
  end
endmodule
